// File: src/pscg_pkg.sv
// Shared constants and types of the power-save clock gating block.
// Assumes a single 125 MHz system clock domain.
package pscg_pkg;

  // ----------------------------------------------------------------------
  // Clock divider register fields
  // ----------------------------------------------------------------------
  localparam int          CDIV_W         = 16;
  localparam int          CDIV_CPU_SLOWDOWN_ENABLE_BIT = 11;
  localparam int          CDIV_RATIO_LO  = 12;
  localparam int          CDIV_RATIO_HI  = 14;
  localparam int          CDIV_ROI_BIT   = 15;
  localparam logic [15:0] CDIV_RESET     = 16'h0000;
  localparam logic [2:0]  RATIO_RESET    = 3'h0;

  // ----------------------------------------------------------------------
  // Oscillator select and power-save operand
  // ----------------------------------------------------------------------
  localparam int          OSC_W          = 3;
  localparam logic [2:0]  OSC_RESET      = 3'h0;
  localparam logic        PS_OP_SLEEP    = 1'b0;
  localparam logic        PS_OP_IDLE     = 1'b1;

  // Widest doze count: ratio 1:256 needs 8 bits.
  localparam int          DOZE_CNT_W     = 8;
  localparam logic [7:0]  DOZE_CNT_RESET = 8'h00;

  typedef enum logic [1:0] {
    PSCG_RUN,
    PSCG_ENTER,
    PSCG_SLEEP,
    PSCG_IDLE
  } pscg_state_t;

endpackage : pscg_pkg

// File: src/pscg_doze_div.sv
// Doze divider: turns the 3-bit ratio field into a CPU clock-enable pulse.
// Assumes ratio is stable or that a change may restart the count.
`timescale 1ns/100ps
`default_nettype none

module pscg_doze_div
  import pscg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       active,
  input  wire logic [2:0] ratio,
  // Result
  output logic            cpu_tick
);

  typedef struct packed {
    logic [DOZE_CNT_W-1:0] cnt;
    logic                  tick;
  } pscg_div_t;

  pscg_div_t s_q;
  pscg_div_t s_d;
  logic [DOZE_CNT_W-1:0] top;

  // Ratio code n divides by 2**n for codes 0 to 6 (1 to 64), and code 7
  // jumps to 256 so that the slowest documented ratio is reachable.
  always_comb begin
    top = (ratio == 3'h7) ? 8'hFF : (8'(8'h01 << ratio) - 8'h01);
    s_d = s_q;
    if (!active) begin
      s_d.cnt  = DOZE_CNT_RESET;
      s_d.tick = 1'b1;
    end else if (s_q.cnt >= top) begin
      s_d.cnt  = DOZE_CNT_RESET;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt  = s_q.cnt + 8'h01;
      s_d.tick = 1'b0;
    end
  end

  // Registered so the enable is glitch-free.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.cnt  <= DOZE_CNT_RESET;
      s_q.tick <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_tick = s_q.tick;

endmodule : pscg_doze_div

`default_nettype wire

// File: src/pscg_top.sv
// Power-save clock gating: Sleep, Idle, Doze and per-module gating.
// Assumes CPU, interrupt logic and peripherals share clk; the gates
// here are enables applied by downstream clock-gating cells.
//
// How it works
// - Only power-save instruction enters Sleep or Idle
// - Oscillator switch ignored while configuration locked
// - Sleep stops system clock and on-chip oscillator
// - Clock failure monitor off during Sleep
// - RC oscillator runs in Sleep with watchdog
// - Watchdog cleared on Sleep entry
// - System-clocked peripherals stopped during Sleep
// - Wake Sleep on interrupt, reset, watchdog timeout
// - Resume on clock source selected at entry
// - Idle stops CPU clock, peripherals keep running
// - Watchdog cleared on Idle entry
// - RC oscillator runs in Idle if needed
// - Wake Idle on interrupt, reset, watchdog timeout
// - CPU clock restored immediately on Idle wake
// - Interrupt during entry held, then wakes
// - Doze slows only the CPU clock
// - Doze enabled by divider bit 11
// - Doze ratio field bits 14:12, reset 1:1
// - Restore-on-interrupt bit 15 ends Doze
// - Power gate stops clocks, blocks register writes
// - Function enable off keeps registers accessible
// - Stop-in-idle halts module during Idle
`timescale 1ns/100ps
`default_nettype none

module pscg_top
  import pscg_pkg::*;
#(
  parameter int N_MOD = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // CPU core
  input  wire logic             power_save_instr,
  input  wire logic             power_save_op,
  input  wire logic             irq_pending,
  input  wire logic             watchdog_timeout,
  // Clock divider register write port
  input  wire logic             clock_divider_we,
  input  wire logic [15:0]      clock_divider_wdata,
  // Oscillator control
  input  wire logic             osc_write,
  input  wire logic [2:0]       new_osc_select,
  input  wire logic             clock_cfg_locked,
  input  wire logic             watchdog_en,
  input  wire logic             clock_fail_monitor_en,
  // Per-module control
  input  wire logic [N_MOD-1:0] module_power_gate,
  input  wire logic [N_MOD-1:0] module_function_enable,
  input  wire logic [N_MOD-1:0] stop_in_idle,
  input  wire logic [N_MOD-1:0] module_ext_clocked,
  input  wire logic [N_MOD-1:0] module_reg_we,
  // Status and clock enables
  output logic [15:0]           clock_divider_reg,
  output logic [2:0]            osc_active_select,
  output logic                  sys_osc_run,
  output logic                  low_power_rc_osc_run,
  output logic                  clock_fail_monitor_act,
  output logic                  watchdog_clear,
  output logic                  cpu_clk_en,
  output logic                  in_sleep,
  output logic                  in_idle,
  output logic                  wake_irq,
  output logic [N_MOD-1:0]      module_clk_en,
  output logic [N_MOD-1:0]      module_func_run,
  output logic [N_MOD-1:0]      module_reg_we_ok
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    pscg_state_t      st;
    logic             op;
    logic             held_irq;
    logic [15:0]      cdiv;
    logic [2:0]       osc;
    logic             osc_run;
    logic             low_power_rc_osc;
    logic             fcm;
    logic             wdt_clr;
    logic             cpu_en;
    logic             slp;
    logic             idl;
    logic             wirq;
    logic [N_MOD-1:0] mclk;
    logic [N_MOD-1:0] mfun;
    logic [N_MOD-1:0] mwe;
  } pscg_top_t;

  pscg_top_t s_q;
  pscg_top_t s_d;
  logic      doze_on;
  logic      cpu_tick;
  logic      wake;
  logic [N_MOD-1:0] mclk_d;

  // Doze counts only while enabled; the enable is a tick on clk.
  assign doze_on = s_q.cdiv[CDIV_CPU_SLOWDOWN_ENABLE_BIT];

  pscg_doze_div u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .active   (doze_on),
    .ratio    (s_q.cdiv[CDIV_RATIO_HI:CDIV_RATIO_LO]),
    .cpu_tick (cpu_tick)
  );

  // Reset wakes by construction; interrupt and watchdog wake here.
  assign wake = irq_pending | watchdog_timeout;

  // ----------------------------------------------------------------------
  // Per-module gating
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_MOD; gi++) begin : g_mod
      // Sleep leaves only externally clocked modules alive.
      always_comb begin
        mclk_d[gi] = !module_power_gate[gi];
        if (s_d.slp && !module_ext_clocked[gi]) begin
          mclk_d[gi] = 1'b0;
        end
        if (s_d.idl && stop_in_idle[gi]) begin
          mclk_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.wdt_clr = 1'b0;
    s_d.wirq    = 1'b0;
    // Divider register write.
    if (clock_divider_we) begin
      s_d.cdiv = clock_divider_wdata;
    end
    // Locked configuration silently drops the switch request.
    if (osc_write && !clock_cfg_locked && s_q.st == PSCG_RUN) begin
      s_d.osc = new_osc_select;
    end
    // Interrupt ends Doze only when restore-on-interrupt is set.
    if (irq_pending && s_q.cdiv[CDIV_ROI_BIT]) begin
      s_d.cdiv[CDIV_CPU_SLOWDOWN_ENABLE_BIT] = 1'b0;
    end
    case (s_q.st)
      PSCG_RUN: begin
        if (power_save_instr) begin
          s_d.st       = PSCG_ENTER;
          s_d.op       = power_save_op;
          s_d.held_irq = 1'b0;
          s_d.wdt_clr  = watchdog_en;
        end
      end
      PSCG_ENTER: begin
        // Watchdog cleared in the cycle the CPU clock stops, one before Sleep/Idle.
        s_d.held_irq = 1'b0;
        s_d.st = (s_q.op == PS_OP_IDLE) ? PSCG_IDLE : PSCG_SLEEP;
      end
      PSCG_SLEEP, PSCG_IDLE: begin
        // A wake held from the entry cycle acts here at once.
        if (wake || s_q.held_irq) begin
          s_d.st   = PSCG_RUN;
          s_d.wirq = irq_pending | s_q.held_irq;
        end
      end
      default: s_d.st = PSCG_RUN;
    endcase
    if (s_q.st == PSCG_ENTER && irq_pending) begin
      s_d.held_irq = 1'b1;
    end
    s_d.slp = (s_d.st == PSCG_SLEEP);
    s_d.idl = (s_d.st == PSCG_IDLE);
    // Osc select is untouched in Sleep, so wake resumes on it.
    s_d.osc_run = !s_d.slp;
    s_d.fcm     = clock_fail_monitor_en && !s_d.slp;
    if (s_d.slp) begin
      s_d.low_power_rc_osc = watchdog_en;
    end else if (s_d.idl) begin
      s_d.low_power_rc_osc = watchdog_en | clock_fail_monitor_en;
    end else begin
      s_d.low_power_rc_osc = 1'b1;
    end
    // CPU halts in Sleep/Idle, restarts on wake, ticks in Doze.
    if (s_d.slp || s_d.idl || s_d.st == PSCG_ENTER) begin
      s_d.cpu_en = 1'b0;
    end else if (s_d.cdiv[CDIV_CPU_SLOWDOWN_ENABLE_BIT]) begin
      s_d.cpu_en = cpu_tick;
    end else begin
      s_d.cpu_en = 1'b1;
    end
    s_d.mclk = mclk_d;
    s_d.mfun = module_function_enable & mclk_d;
    s_d.mwe  = module_reg_we & ~module_power_gate;
  end

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.st       <= PSCG_RUN;
      s_q.cdiv     <= CDIV_RESET;
      s_q.osc      <= OSC_RESET;
      s_q.osc_run  <= 1'b1;
      s_q.low_power_rc_osc     <= 1'b1;
      s_q.cpu_en   <= 1'b1;
      s_q.mclk     <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign clock_divider_reg      = s_q.cdiv;
  assign osc_active_select      = s_q.osc;
  assign sys_osc_run            = s_q.osc_run;
  assign low_power_rc_osc_run   = s_q.low_power_rc_osc;
  assign clock_fail_monitor_act = s_q.fcm;
  assign watchdog_clear         = s_q.wdt_clr;
  assign cpu_clk_en             = s_q.cpu_en;
  assign in_sleep               = s_q.slp;
  assign in_idle                = s_q.idl;
  assign wake_irq               = s_q.wirq;
  assign module_clk_en          = s_q.mclk;
  assign module_func_run        = s_q.mfun;
  assign module_reg_we_ok       = s_q.mwe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_enter_only_by_instr;
    @(posedge clk) disable iff (!rst_n)
      (s_q.st == PSCG_RUN && !power_save_instr) |=> !in_sleep && !in_idle;
  endproperty
  a_enter_only_by_instr: assert property (p_enter_only_by_instr)
    else $error("Power-save mode entered without the instruction.");

  property p_locked_osc;
    @(posedge clk) disable iff (!rst_n)
      clock_cfg_locked |=> $stable(osc_active_select);
  endproperty
  a_locked_osc: assert property (p_locked_osc)
    else $error("Oscillator changed while locked.");

  property p_sleep_clocks;
    @(posedge clk) disable iff (!rst_n)
      in_sleep |-> !sys_osc_run && !clock_fail_monitor_act && !cpu_clk_en;
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("Clocks left running in Sleep.");

  property p_sleep_low_power_rc_osc;
    @(posedge clk) disable iff (!rst_n)
      ##1 (in_sleep && $past(watchdog_en)) |-> low_power_rc_osc_run;
  endproperty
  a_sleep_low_power_rc_osc: assert property (p_sleep_low_power_rc_osc)
    else $error("RC oscillator stopped in Sleep with watchdog on.");

  property p_wdt_clear;
    @(posedge clk) disable iff (!rst_n)
      (s_q.st == PSCG_RUN && power_save_instr && watchdog_en)
        |=> watchdog_clear ##1 (in_sleep || in_idle);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("Watchdog not cleared before entry.");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      ((in_sleep || in_idle) && watchdog_timeout) |=> !in_sleep && !in_idle;
  endproperty
  a_wake: assert property (p_wake)
    else $error("No wake on watchdog time-out.");

  property p_idle_cpu_restart;
    @(posedge clk) disable iff (!rst_n)
      (in_idle && irq_pending && !doze_on) |=> cpu_clk_en;
  endproperty
  a_idle_cpu_restart: assert property (p_idle_cpu_restart)
    else $error("CPU clock not restored on Idle wake.");

  property p_held_irq;
    @(posedge clk) disable iff (!rst_n)
      (s_q.st == PSCG_ENTER && irq_pending) |=> ##1 !in_sleep && !in_idle;
  endproperty
  a_held_irq: assert property (p_held_irq)
    else $error("Interrupt during entry not honoured.");

  property p_power_gate;
    @(posedge clk) disable iff (!rst_n)
      module_power_gate[0] |=> !module_clk_en[0] && !module_reg_we_ok[0];
  endproperty
  a_power_gate: assert property (p_power_gate)
    else $error("Gated module still clocked or writable.");

  property p_roi;
    @(posedge clk) disable iff (!rst_n)
      (irq_pending && clock_divider_reg[CDIV_ROI_BIT] && !clock_divider_we)
        |=> !clock_divider_reg[CDIV_CPU_SLOWDOWN_ENABLE_BIT];
  endproperty
  a_roi: assert property (p_roi)
    else $error("Doze not ended on interrupt.");

  c_sleep: cover property (@(posedge clk) disable iff (!rst_n)
    in_sleep ##1 !in_sleep);
  c_idle: cover property (@(posedge clk) disable iff (!rst_n)
    in_idle ##1 !in_idle);
  c_doze: cover property (@(posedge clk) disable iff (!rst_n)
    doze_on && !cpu_clk_en ##1 cpu_clk_en);

endmodule : pscg_top

`default_nettype wire

// File: dv/pscg_irq_model.sv
// Interrupt source model standing where the CPU's interrupt logic sits.
// Assumes one clock shared with the block; arm is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

module pscg_irq_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bench control
  input  wire logic       arm,
  input  wire logic [7:0] delay,
  // Block side
  input  wire logic       wake_irq,
  output logic            irq_pending
);
  logic [7:0] cnt_q;
  logic [2:0] hold_q;

  // ----------------------------------------------------------------
  // Request generator
  // ----------------------------------------------------------------
  // The request is a level held until the wake is seen or a handler
  // would have served it, so a held-off request is never lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q       <= 8'h00;
      hold_q      <= 3'h0;
      irq_pending <= 1'b0;
    end else if (arm && delay == 8'h00) begin
      irq_pending <= 1'b1;
      hold_q      <= 3'h6;
    end else if (arm) begin
      cnt_q <= delay;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        irq_pending <= 1'b1;
        hold_q      <= 3'h6;
      end
    end else if (irq_pending) begin
      hold_q <= hold_q - 3'h1;
      if (wake_irq || hold_q == 3'h1) begin
        irq_pending <= 1'b0;
      end
    end
  end
endmodule : pscg_irq_model

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench of the power-save clock gating block.
// Assumes the block's registered outputs lag their cause by one cycle.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import pscg_pkg::*;
  localparam int N_MOD = 8;
  logic clk = 1'b0, rst_n = 1'b0, irq_pending, irq_arm = 1'b0;
  logic power_save_instr = 1'b0, power_save_op = 1'b0;
  logic watchdog_timeout = 1'b0, clock_divider_we = 1'b0;
  logic osc_write = 1'b0, clock_cfg_locked = 1'b0;
  logic watchdog_en = 1'b1, clock_fail_monitor_en = 1'b1;
  logic [15:0] clock_divider_wdata = 16'h0000, clock_divider_reg;
  logic [7:0] irq_delay = 8'h00;
  logic [2:0] new_osc_select = 3'h0, osc_active_select, v;
  logic [N_MOD-1:0] module_power_gate = '0, module_function_enable = '1;
  logic [N_MOD-1:0] stop_in_idle = '0, module_ext_clocked = '0;
  logic [N_MOD-1:0] module_reg_we = '0, module_clk_en, module_func_run;
  logic [N_MOD-1:0] module_reg_we_ok;
  logic sys_osc_run, low_power_rc_osc_run, clock_fail_monitor_act;
  logic watchdog_clear, cpu_clk_en, in_sleep, in_idle, wake_irq;
  logic [31:0] seed = 32'hC0CF783F;
  int n_fail = 0, compares = 0, k, r, ticks;

  pscg_top #(.N_MOD(N_MOD)) i_pscg_top (.clk, .rst_n, .power_save_instr,
    .power_save_op, .irq_pending, .watchdog_timeout, .clock_divider_we,
    .clock_divider_wdata, .osc_write, .new_osc_select, .clock_cfg_locked,
    .watchdog_en, .clock_fail_monitor_en, .module_power_gate,
    .module_function_enable, .stop_in_idle, .module_ext_clocked,
    .module_reg_we, .clock_divider_reg, .osc_active_select, .sys_osc_run,
    .low_power_rc_osc_run, .clock_fail_monitor_act, .watchdog_clear,
    .cpu_clk_en, .in_sleep, .in_idle, .wake_irq, .module_clk_en,
    .module_func_run, .module_reg_we_ok);
  pscg_irq_model i_pscg_irq_model (.clk, .rst_n, .arm(irq_arm),
    .delay(irq_delay), .wake_irq, .irq_pending);

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Peripheral cycles per CPU cycle for a ratio code; code 7 is 256.
  function automatic int doze_period(input int code);
    return (code == 7) ? 256 : (1 << code);
  endfunction : doze_period
  task automatic chb(input string nm, input logic e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chb
  task automatic chv(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chv
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Returns in the cycle after the edge that took the instruction.
  task automatic psave(input logic op, input logic arm);
    power_save_op = op;
    power_save_instr = 1'b1;
    irq_arm = arm;
    irq_delay = 8'h00;
    cyc(1);
    power_save_instr = 1'b0;
    irq_arm = 1'b0;
  endtask : psave
  task automatic wr_div(input logic [15:0] d);
    clock_divider_wdata = d;
    clock_divider_we = 1'b1;
    cyc(1);
    clock_divider_we = 1'b0;
    cyc(1);
  endtask : wr_div
  // Bounded wait for the block to leave Sleep or Idle.
  task automatic wait_wake;
    for (k = 0; k < 60 && (in_sleep | in_idle) !== 1'b0; k++) cyc(1);
  endtask : wait_wake
  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog: the run needs about 2100 cycles; 20000 means a hang.
  initial begin
    #160000;
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    chv("divider", CDIV_RESET, clock_divider_reg);
    chv("mod_clk", 16'h00FF, 16'(module_clk_en));
    chb("cpu_clk", 1'b1, cpu_clk_en);
    rst_n = 1'b1;
    cyc(5);
    chb("sleep", 1'b0, in_sleep | in_idle);
    $display("test reset done");
    clock_cfg_locked = 1'b1;
    new_osc_select = 3'h5;
    osc_write = 1'b1;
    cyc(1);
    osc_write = 1'b0;
    cyc(2);
    chv("osc_lock", 16'(OSC_RESET), 16'(osc_active_select));
    seed = lfsr(seed);
    v = seed[2:0] | 3'h1;
    clock_cfg_locked = 1'b0;
    new_osc_select = v;
    osc_write = 1'b1;
    cyc(1);
    osc_write = 1'b0;
    cyc(2);
    chv("osc_sel", 16'(v), 16'(osc_active_select));
    $display("test osc done");
    seed = lfsr(seed);
    module_ext_clocked = seed[7:0];
    psave(PS_OP_SLEEP, 1'b0);
    chb("wd_clr", 1'b1, watchdog_clear);
    chb("cpu_off", 1'b0, cpu_clk_en);
    cyc(1);
    chb("in_sleep", 1'b1, in_sleep);
    chb("sys_osc", 1'b0, sys_osc_run);
    chb("fcm", 1'b0, clock_fail_monitor_act);
    chb("low_power_rc_osc", 1'b1, low_power_rc_osc_run);
    chv("slp_clk", 16'(module_ext_clocked), 16'(module_clk_en));
    irq_delay = 8'h05;
    irq_arm = 1'b1;
    cyc(1);
    irq_arm = 1'b0;
    wait_wake();
    chb("wake_irq", 1'b1, wake_irq);
    chb("sys_osc", 1'b1, sys_osc_run);
    chv("osc_back", 16'(v), 16'(osc_active_select));
    cyc(1);
    chb("fcm_on", 1'b1, clock_fail_monitor_act);
    $display("test sleep done");
    cyc(8);
    seed = lfsr(seed);
    stop_in_idle = seed[7:0];
    module_power_gate = seed[15:8];
    psave(PS_OP_IDLE, 1'b0);
    chb("wd_clr", 1'b1, watchdog_clear);
    cyc(1);
    chb("in_idle", 1'b1, in_idle);
    chb("cpu_off", 1'b0, cpu_clk_en);
    chb("sys_osc", 1'b1, sys_osc_run);
    chb("low_power_rc_osc", 1'b1, low_power_rc_osc_run);
    chv("idl_clk", {8'h00, ~stop_in_idle & ~module_power_gate},
        16'(module_clk_en));
    watchdog_timeout = 1'b1;
    cyc(1);
    watchdog_timeout = 1'b0;
    wait_wake();
    chb("wake_irq", 1'b0, wake_irq);
    chb("cpu_on", 1'b1, cpu_clk_en);
    stop_in_idle = '0;
    $display("test idle done");
    cyc(8);
    psave(PS_OP_SLEEP, 1'b1);
    cyc(1);
    chb("held", 1'b1, in_sleep);
    cyc(1);
    chb("held_out", 1'b0, in_sleep);
    chb("held_irq", 1'b1, wake_irq);
    $display("test coincident done");
    for (r = 0; r < 4; r++) begin
      seed = lfsr(seed);
      {module_reg_we, module_power_gate, module_function_enable} =
        seed[23:0];
      cyc(2);
      chv("we_ok", 16'(module_reg_we & ~module_power_gate),
          16'(module_reg_we_ok));
      chv("gclk", 16'h0000, 16'(module_clk_en & module_power_gate));
      chv("func", 16'(module_function_enable & ~module_power_gate),
          16'(module_func_run & ~module_power_gate));
    end
    $display("test gate done");
    for (r = 0; r < 8; r++) begin
      wr_div({1'b0, 3'(r), 1'b1, 11'h000});
      chv("div_wr", {1'b0, 3'(r), 1'b1, 11'h000}, clock_divider_reg);
      cyc(doze_period(r) + 2);
      ticks = 0;
      repeat (4 * doze_period(r)) begin
        @(negedge clk);
        ticks += int'(cpu_clk_en === 1'b1);
      end
      chv("doze", 16'h0004, 16'(ticks));
      chv("periph", 16'h00FF, 16'(module_clk_en | module_power_gate));
    end
    $display("test doze done");
    wr_div({1'b1, 3'h2, 1'b1, 11'h000});
    irq_delay = 8'h03;
    irq_arm = 1'b1;
    cyc(1);
    irq_arm = 1'b0;
    cyc(10);
    chb("roi", 1'b0, clock_divider_reg[CDIV_CPU_SLOWDOWN_ENABLE_BIT]);
    wr_div({1'b0, 3'h2, 1'b1, 11'h000});
    irq_arm = 1'b1;
    cyc(1);
    irq_arm = 1'b0;
    cyc(10);
    chb("no_roi", 1'b1, clock_divider_reg[CDIV_CPU_SLOWDOWN_ENABLE_BIT]);
    $display("test restore done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
